// ===== dv/epl_chk_assertions.sv
// Port checker for the outside PID loop
`timescale 1ns/1ns
module epl_chk (
  // Clock and reset
  input logic        aclk,
  input logic        aresetn,
  input logic        ce,
  // Register bus
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // Loop
  input logic        loop_disable_input,
  input logic [31:0] loop_output,
  input logic        loop_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  a_rd_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_release: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  a_wr_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_wr_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_idle_zero: assert property (
    !loop_active [*3] |-> loop_output == 32'h0)
    else $error("output not zero while idle");
  a_disable_stop: assert property (
    loop_disable_input [*4] |-> !loop_active)
    else $error("loop runs while disabled");
  // One update per pass; a burst of changes means a stage leaks out
  a_out_once: assert property (
    disable iff (!aresetn || !loop_active)
    $changed(loop_output) |=> $stable(loop_output) [*8])
    else $error("output changed twice in a pass");
endmodule
bind epl_top epl_chk u_chk (.aclk, .aresetn, .ce, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .loop_disable_input, .loop_output, .loop_active);

// ===== dv/epl_ctrl_model.sv
// Upper-level controller: sources, main speed and pins
`timescale 1ns/1ns
module epl_ctrl_model (
  // Values toward the loop
  output logic [127:0] source_values,
  output logic [15:0]  main_speed,
  // Pins
  output logic         loop_disable_input,
  output logic         alternate_gain_select
);
  initial begin
    source_values = 128'h0;
    main_speed = 16'h2710;
    loop_disable_input = 1'b0;
    alternate_gain_select = 1'b0;
  end
  // Callers run just after an edge, so changes never race the sampling
  task automatic set_word(input int n, input logic [15:0] v);
    source_values[16*n +: 16] <= v;
  endtask
  task automatic set_speed(input logic [15:0] v);
    main_speed <= v;
  endtask
  task automatic set_pins(input logic d, input logic a);
    loop_disable_input <= d;
    alternate_gain_select <= a;
  endtask
endmodule

// ===== dv/epl_top_tb.sv
// Self-checking bench for the outside PID loop
`timescale 1ns/1ns
`include "epl_defs.vh"
module epl_top_tb;
  logic         aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic         arvalid = 1'b0, rready = 1'b0;
  logic [31:0]  wdata = 32'h0;
  wire          awready, wready, bvalid, arready, rvalid, dis, alt, act;
  wire  [1:0]   bresp, rresp;
  wire  [31:0]  rdata, out;
  wire  [127:0] src;
  wire  [15:0]  spd;
  int           n_fail = 0, check_count = 0;
  logic [31:0]  rv [15] = '{`EPL_R_CTRL, `EPL_R_KEYSP, `EPL_R_KP1,
    `EPL_R_TI1, `EPL_R_TD, `EPL_R_LAG, `EPL_R_SCALE, `EPL_R_KP2,
    `EPL_R_TI2, `EPL_R_GRAMP, `EPL_R_SRAMP, `EPL_R_HI, `EPL_R_LO,
    `EPL_R_TS, `EPL_R_MINSPD};
  always #5 aclk = ~aclk;
  epl_ctrl_model ctl (.source_values(src), .main_speed(spd),
    .loop_disable_input(dis), .alternate_gain_select(alt));
  // Short millisecond keeps a pass inside one sample period
  epl_top #(.CYC_PER_MS(1000)) dut (.aclk(aclk), .aresetn(aresetn),
    .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .loop_disable_input(dis), .alternate_gain_select(alt),
    .source_values(src), .main_speed(spd), .loop_output(out),
    .loop_active(act));
  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 50) begin
      n_fail++;
      print_verdict();
    end
  endtask
  // Ready rises with the request and stays up; valid seen at an edge ends it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    hang(n);
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    hang(n);
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic wait_out(input logic [31:0] e);
    for (int n = 0; n < 6000 && out !== e; n++) @(posedge aclk);
    chk(out, e);
    if (out !== e) print_verdict();
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    ctl.set_word(1, 16'h03E8);
    for (int i = 0; i < 15; i++) begin
      rd(8'(i * 4), rv[i], `EPL_OKAY);
    end
    rd(8'h80, 32'h0, `EPL_SLVERR);
    wr(8'h3C, 32'h0, `EPL_SLVERR);
    wr(8'h2C, 32'hFFFFFB50, `EPL_OKAY);
    rd(8'h2C, `EPL_R_LO, `EPL_OKAY);
    wr(8'h2C, `EPL_R_HI, `EPL_OKAY);
    wr(8'h0C, 32'h0, `EPL_OKAY);
    wr(8'h24, 32'h0, `EPL_OKAY);
    wr(8'h00, 32'h0000010D, `EPL_OKAY);
    wait_out(32'h000007D0);
    chk({31'h0, act}, 32'h1);
    rd(8'h44, 32'h00001388, `EPL_OKAY);
    rd(8'h48, 32'h000003E8, `EPL_OKAY);
    wr(8'h00, 32'h0000010F, `EPL_OKAY);
    wait_out(32'hFFFFF830);
    rd(8'h40, 32'hFFFFF830, `EPL_OKAY);
    wr(8'h00, 32'h0000010D, `EPL_OKAY);
    ctl.set_pins(1'b0, 1'b1);
    wait_out(32'h00000FA0);
    wr(8'h2C, 32'h0000012C, `EPL_OKAY);
    wait_out(32'h00000BB8);
    wr(8'h18, 32'h000001F4, `EPL_OKAY);
    wait_out(32'h000005DC);
    wr(8'h18, `EPL_R_SCALE, `EPL_OKAY);
    wait_out(32'h00000BB8);
    wr(8'h00, 32'h00000109, `EPL_OKAY);
    ctl.set_speed(16'h07D0);
    wait_out(32'h00000258);
    ctl.set_speed(16'h01F4);
    wait_out(32'h0000012C);
    ctl.set_pins(1'b1, 1'b1);
    wait_out(32'h0);
    chk({31'h0, act}, 32'h0);
    print_verdict();
  end
endmodule

// ===== rtl/epl_defs.vh
// Constants shared by the outside PID loop files
`ifndef EPL_DEFS_VH
`define EPL_DEFS_VH

// Register word indexes; byte address is index * 4
`define EPL_I_CTRL    4'h0
`define EPL_I_KEYSP   4'h1
`define EPL_I_KP1     4'h2
`define EPL_I_TI1     4'h3
`define EPL_I_TD      4'h4
`define EPL_I_LAG     4'h5
`define EPL_I_SCALE   4'h6
`define EPL_I_KP2     4'h7
`define EPL_I_TI2     4'h8
`define EPL_I_GRAMP   4'h9
`define EPL_I_SRAMP   4'hA
`define EPL_I_HI      4'hB
`define EPL_I_LO      4'hC
`define EPL_I_TS      4'hD
`define EPL_I_MINSPD  4'hE
`define EPL_I_STATUS  4'hF
`define EPL_NUM_CFG   15
// Monitor words sit above the 16-word block
`define EPL_A_OUTMON  8'h40
`define EPL_A_SPMON   8'h44
`define EPL_A_FBMON   8'h48

// Control word fields
`define EPL_C_EN      0
`define EPL_C_NEG     1
`define EPL_C_FIXED   2
`define EPL_C_APP     3
`define EPL_C_SPSRC   7:4
`define EPL_C_FBSRC   11:8

// Reset values
`define EPL_R_CTRL    32'h00000101
`define EPL_R_KEYSP   32'h00001388
`define EPL_R_KP1     32'h000001F4
`define EPL_R_TI1     32'h00000064
`define EPL_R_TD      32'h00000000
`define EPL_R_LAG     32'h00000000
`define EPL_R_SCALE   32'h000003E8
`define EPL_R_KP2     32'h000003E8
`define EPL_R_TI2     32'h000000C8
`define EPL_R_GRAMP   32'h0000012C
`define EPL_R_SRAMP   32'h00000000
`define EPL_R_HI      32'h000003E8
`define EPL_R_LO      32'hFFFFFC18
`define EPL_R_TS      32'h00000001
`define EPL_R_MINSPD  32'h00000064

// Scaling: values in 0.01 %, gains in 0.1 %, times in 0.1 s or ms
`define EPL_GAIN_UNIT 32'h000003E8
`define EPL_PCT_FULL  48'h000000002710
`define EPL_PCT_DEN   32'h00002710
`define EPL_KP_FULL   48'h000000002710
`define EPL_TI_FULL   48'h0000000007D0
`define EPL_DSEC_MS   32'h00000064
`define EPL_LIM_SCALE 32'h0000000A
`define EPL_INT_FRAC  8
`define EPL_GAIN_FRAC 16
`define EPL_RAMP_FRAC 8
`define EPL_LAST_STG  4'h8

// Timing
`define EPL_CLK_NS    10
`define EPL_MS_NS     1000000

// Bus answers
`define EPL_OKAY      2'b00
`define EPL_SLVERR    2'b10

`endif

// ===== rtl/epl_div.v
// Sequential unsigned divider shared by the loop arithmetic
`timescale 1ns/1ns
module epl_div #(
  parameter NW = 48,
  parameter DW = 32
) (
  // Clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          ce,
  // Operands
  input  wire          start,
  input  wire [NW-1:0] num,
  input  wire [DW-1:0] den,
  // Result
  output reg           done,
  output reg  [NW-1:0] quo
);

  reg  [DW-1:0] rem;
  reg  [6:0]    cnt;
  wire [DW:0]   shifted = {rem, quo[NW-1]};
  wire          fits    = shifted >= {1'b0, den};
  wire [DW:0]   diff    = shifted - {1'b0, den};

  // Zero divisor yields all ones; callers never use that quotient
  always @(posedge aclk) begin
    if (!aresetn) begin
      rem  <= {DW{1'b0}};
      quo  <= {NW{1'b0}};
      cnt  <= 7'h00;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        rem <= {DW{1'b0}};
        quo <= num;
        cnt <= NW[6:0];
      end else if (cnt != 7'h00) begin
        rem  <= fits ? diff[DW-1:0] : shifted[DW-1:0];
        quo  <= {quo[NW-2:0], fits};
        cnt  <= cnt - 7'h01;
        done <= (cnt == 7'h01);
      end
    end
  end

endmodule

// ===== rtl/epl_slew.v
// Rate limiter: moves a value toward its target by a step per tick
`timescale 1ns/1ns
module epl_slew #(
  parameter W = 32
) (
  // Clock and reset
  input  wire                aclk,
  input  wire                aresetn,
  input  wire                ce,
  // Control
  input  wire                snap,
  input  wire                tick,
  input  wire signed [W-1:0] target,
  input  wire        [W-1:0] step,
  // Result
  output reg  signed [W-1:0] value
);

  wire signed [W:0] diff  = {target[W-1], target} - {value[W-1], value};
  wire signed [W:0] stp   = {1'b0, step};

  always @(posedge aclk) begin
    if (!aresetn) begin
      value <= {W{1'b0}};
    end else if (ce) begin
      if (snap) begin
        value <= target;
      end else if (tick) begin
        if (diff > stp)
          value <= value + step;
        else if (diff < -stp)
          value <= value - step;
        else
          value <= target;
      end
    end
  end

endmodule

// ===== rtl/epl_top.v
// Outside PID loop: AXI4-Lite settings, sampled regulator, monitors
`timescale 1ns/1ns
`include "epl_defs.vh"
module epl_top #(
  parameter CYC_PER_MS = `EPL_MS_NS / `EPL_CLK_NS,
  parameter AW         = 8,
  parameter SW         = 16
) (
  // Clock, reset, enable
  input  wire            aclk,
  input  wire            aresetn,
  input  wire            ce,
  // AXI4-Lite write
  input  wire [AW-1:0]   s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output wire            s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output wire            s_axi_wready,
  output reg  [1:0]      s_axi_bresp,
  output reg             s_axi_bvalid,
  input  wire            s_axi_bready,
  // AXI4-Lite read
  input  wire [AW-1:0]   s_axi_araddr,
  input  wire            s_axi_arvalid,
  output wire            s_axi_arready,
  output reg  [31:0]     s_axi_rdata,
  output reg  [1:0]      s_axi_rresp,
  output reg             s_axi_rvalid,
  input  wire            s_axi_rready,
  // Pins
  input  wire            loop_disable_input,
  input  wire            alternate_gain_select,
  // Sources, same clock: eight signed words in 0.01 %
  input  wire [8*SW-1:0] source_values,
  input  wire [15:0]     main_speed,
  // Results
  output reg  [31:0]     loop_output,
  output reg             loop_active
);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [1:0] dis_sync;
  reg [1:0] alt_sync;
  always @(posedge aclk) begin
    if (!aresetn) begin
      dis_sync <= 2'b00;
      alt_sync <= 2'b00;
    end else if (ce) begin
      dis_sync <= {dis_sync[0], loop_disable_input};
      alt_sync <= {alt_sync[0], alternate_gain_select};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register file
  reg  [31:0] cfg [0:`EPL_NUM_CFG-1];
  reg         aw_got;
  reg         w_got;
  reg  [AW-1:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire [3:0]  w_idx  = aw_addr[5:2];
  wire        w_map  = (aw_addr[AW-1:6] == 0) && (w_idx != `EPL_I_STATUS);
  wire [31:0] ctrl   = cfg[`EPL_I_CTRL];
  reg  [31:0] merged;
  reg  [31:0] next_wval;
  reg  [31:0] setpoint_monitor;
  reg  [31:0] feedback_monitor;
  reg         start_phase;
  integer     i;

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  function [31:0] rst_val;
    input [3:0] idx;
    begin
      case (idx)
        `EPL_I_CTRL:   rst_val = `EPL_R_CTRL;
        `EPL_I_KEYSP:  rst_val = `EPL_R_KEYSP;
        `EPL_I_KP1:    rst_val = `EPL_R_KP1;
        `EPL_I_TI1:    rst_val = `EPL_R_TI1;
        `EPL_I_TD:     rst_val = `EPL_R_TD;
        `EPL_I_LAG:    rst_val = `EPL_R_LAG;
        `EPL_I_SCALE:  rst_val = `EPL_R_SCALE;
        `EPL_I_KP2:    rst_val = `EPL_R_KP2;
        `EPL_I_TI2:    rst_val = `EPL_R_TI2;
        `EPL_I_GRAMP:  rst_val = `EPL_R_GRAMP;
        `EPL_I_SRAMP:  rst_val = `EPL_R_SRAMP;
        `EPL_I_HI:     rst_val = `EPL_R_HI;
        `EPL_I_LO:     rst_val = `EPL_R_LO;
        `EPL_I_TS:     rst_val = `EPL_R_TS;
        `EPL_I_MINSPD: rst_val = `EPL_R_MINSPD;
        default:       rst_val = 32'h00000000;
      endcase
    end
  endfunction

  // Byte merge, then keep lower limit at or below upper limit
  always @* begin
    merged = cfg[w_idx[3:0] == `EPL_I_STATUS ? 4'h0 : w_idx];
    for (i = 0; i < 4; i = i + 1)
      if (w_strb[i])
        merged[8*i +: 8] = w_data[8*i +: 8];
    next_wval = merged;
    if (w_idx == `EPL_I_HI && $signed(merged) < $signed(cfg[`EPL_I_LO]))
      next_wval = cfg[`EPL_I_LO];
    if (w_idx == `EPL_I_LO && $signed(merged) > $signed(cfg[`EPL_I_HI]))
      next_wval = cfg[`EPL_I_HI];
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < `EPL_NUM_CFG; i = i + 1)
        cfg[i] <= rst_val(i[3:0]);
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr      <= {AW{1'b0}};
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `EPL_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_got && w_got) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_map ? `EPL_OKAY : `EPL_SLVERR;
        if (w_map)
          cfg[w_idx] <= next_wval;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Reads: settings, status and monitors
  wire [3:0] r_idx = s_axi_araddr[5:2];
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `EPL_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `EPL_OKAY;
        if (s_axi_araddr[AW-1:6] == 0 && r_idx != `EPL_I_STATUS)
          s_axi_rdata <= cfg[r_idx];
        else if (s_axi_araddr[AW-1:6] == 0)
          s_axi_rdata <= {29'h0, start_phase, alt_sync[1], loop_active};
        else if (s_axi_araddr == `EPL_A_OUTMON)
          s_axi_rdata <= loop_output;
        else if (s_axi_araddr == `EPL_A_SPMON)
          s_axi_rdata <= setpoint_monitor;
        else if (s_axi_araddr == `EPL_A_FBMON)
          s_axi_rdata <= feedback_monitor;
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `EPL_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Run condition, sources, sample tick
  // Does not look at the drive's run state, only the application choice, the enable bit and the disable pin
  wire run = ctrl[`EPL_C_APP] && ctrl[`EPL_C_EN] && !dis_sync[1];
  wire [3:0] sp_src = ctrl[`EPL_C_SPSRC];
  wire [3:0] fb_src = ctrl[`EPL_C_FBSRC];
  wire [2:0] sp_sel = sp_src[2:0] - 3'h1;
  wire signed [31:0] sp_val = (sp_src == 4'h0) ? cfg[`EPL_I_KEYSP] :
    {{(32-SW){source_values[SW*sp_sel+SW-1]}},
     source_values[SW*sp_sel +: SW]};
  wire signed [31:0] fb_val = {{(32-SW){source_values[SW*fb_src[2:0]+SW-1]}},
     source_values[SW*fb_src[2:0] +: SW]};
  wire signed [31:0] err = sp_val - fb_val;
  wire [31:0] ts_ms = cfg[`EPL_I_TS];

  reg [23:0] tick_cnt;
  wire       sample = (tick_cnt == 24'h000000);
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt         <= 24'h000000;
      setpoint_monitor <= 32'h00000000;
      feedback_monitor <= 32'h00000000;
    end else if (ce) begin
      setpoint_monitor <= sp_val;
      feedback_monitor <= fb_val;
      if (sample)
        tick_cnt <= ts_ms[23:0] * CYC_PER_MS[23:0] - 24'h000001;
      else
        tick_cnt <= tick_cnt - 24'h000001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Gain and start slewing
  wire signed [31:0] kp_act;
  wire signed [31:0] ti_act;
  wire signed [31:0] ramp_val;
  reg  [31:0] kp_step;
  reg  [31:0] ti_step;
  reg  [31:0] ramp_step;
  reg  signed [31:0] lag_y;
  reg  [1:0]  state;
  reg  [3:0]  stage;
  localparam ST_IDLE = 2'b00;
  localparam ST_LOAD = 2'b01;
  localparam ST_WAIT = 2'b10;
  localparam ST_GAP  = 2'b11;
  wire gain_tick = (state == ST_GAP) && (stage == 4'h3);
  wire ramp_tick = (state == ST_GAP) && (stage == `EPL_LAST_STG);
  wire [31:0] kp_sel = alt_sync[1] ? cfg[`EPL_I_KP2] : cfg[`EPL_I_KP1];
  wire [31:0] ti_sel = alt_sync[1] ? cfg[`EPL_I_TI2] : cfg[`EPL_I_TI1];
  wire gain_snap = !run || (cfg[`EPL_I_GRAMP] == 32'h0);

  epl_slew #(.W(32)) u_kp (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .snap(gain_snap),
    .tick(gain_tick), .target(kp_sel << `EPL_GAIN_FRAC),
    .step(kp_step), .value(kp_act));
  epl_slew #(.W(32)) u_ti (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .snap(gain_snap),
    .tick(gain_tick), .target(ti_sel << `EPL_GAIN_FRAC),
    .step(ti_step), .value(ti_act));
  epl_slew #(.W(32)) u_ramp (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .snap(!run || !start_phase), .tick(ramp_tick),
    .target(run ? (lag_y <<< `EPL_RAMP_FRAC) : 32'sh0),
    .step(ramp_step), .value(ramp_val));

  //////////////////////////////////////////////////////////////////////////
  // Stage arithmetic through one shared divider
  reg  signed [31:0] p_term;
  reg  signed [31:0] integ;
  reg  signed [31:0] d_term;
  reg  signed [31:0] err_prev;
  reg  signed [31:0] scaled;
  reg  [47:0] num;
  reg  [31:0] den;
  reg         neg;
  wire        div_done;
  wire [47:0] quo;
  wire signed [31:0] lim_hi = $signed(cfg[`EPL_I_HI]) * $signed(`EPL_LIM_SCALE);
  wire signed [31:0] lim_lo = $signed(cfg[`EPL_I_LO]) * $signed(`EPL_LIM_SCALE);
  wire signed [31:0] sum = p_term + (integ >>> `EPL_INT_FRAC) + d_term;
  wire signed [31:0] u_clamp = (sum > lim_hi) ? lim_hi :
                               (sum < lim_lo) ? lim_lo : sum;
  wire signed [31:0] d_in = d_term + (err - err_prev);
  wire signed [31:0] lag_in = scaled - lag_y;
  wire signed [31:0] ramp_int = ramp_val >>> `EPL_RAMP_FRAC;
  wire [31:0] min_spd = cfg[`EPL_I_MINSPD] * `EPL_LIM_SCALE;
  wire [31:0] spd_ratio = ({16'h0, main_speed} < min_spd) ?
                          min_spd : {16'h0, main_speed};
  wire signed [31:0] div_res = neg ? -$signed(quo[31:0]) : $signed(quo[31:0]);
  wire [31:0] gramp_ms = cfg[`EPL_I_GRAMP] * `EPL_DSEC_MS;
  wire [31:0] ti_ms = ti_act[31:16] * `EPL_DSEC_MS;

  function [31:0] mag;
    input [31:0] v;
    begin
      mag = v[31] ? (~v + 32'h1) : v;
    end
  endfunction

  always @* begin
    num = 48'h0;
    den = 32'h1;
    neg = 1'b0;
    case (stage)
      4'h0: begin
        num = (`EPL_KP_FULL << `EPL_GAIN_FRAC) * ts_ms;
        den = gramp_ms;
      end
      4'h1: begin
        num = (`EPL_TI_FULL << `EPL_GAIN_FRAC) * ts_ms;
        den = gramp_ms;
      end
      4'h2: begin
        num = (`EPL_PCT_FULL << `EPL_RAMP_FRAC) * ts_ms;
        den = cfg[`EPL_I_SRAMP] * `EPL_DSEC_MS;
      end
      4'h3: begin
        num = mag(err) * kp_act[31:16];
        den = `EPL_GAIN_UNIT;
        neg = err[31];
      end
      4'h4: begin
        num = (mag(err) * ts_ms) << `EPL_INT_FRAC;
        den = ti_ms;
        neg = err[31];
      end
      4'h5: begin
        num = mag(d_in) * cfg[`EPL_I_TD];
        den = cfg[`EPL_I_TD] + ts_ms;
        neg = d_in[31];
      end
      4'h6: begin
        num = mag(u_clamp) * cfg[`EPL_I_SCALE];
        den = `EPL_GAIN_UNIT;
        neg = u_clamp[31] ^ ctrl[`EPL_C_NEG];
      end
      4'h7: begin
        num = mag(lag_in) * ts_ms;
        den = cfg[`EPL_I_LAG] + ts_ms;
        neg = lag_in[31];
      end
      4'h8: begin
        num = mag(ramp_int) * spd_ratio;
        den = `EPL_PCT_DEN;
        neg = ramp_int[31];
      end
      default: begin
        num = 48'h0;
        den = 32'h1;
        neg = 1'b0;
      end
    endcase
  end

  epl_div #(.NW(48), .DW(32)) u_div (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .start(state == ST_LOAD),
    .num(num), .den(den), .done(div_done), .quo(quo));

  //////////////////////////////////////////////////////////////////////////
  // Sequencer: one pass per sample while running
  wire signed [31:0] integ_next = integ + div_res;
  wire signed [31:0] i_hi = lim_hi <<< `EPL_INT_FRAC;
  wire signed [31:0] i_lo = lim_lo <<< `EPL_INT_FRAC;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state       <= ST_IDLE;
      stage       <= 4'h0;
      p_term      <= 32'sh0;
      integ       <= 32'sh0;
      d_term      <= 32'sh0;
      err_prev    <= 32'sh0;
      scaled      <= 32'sh0;
      lag_y       <= 32'sh0;
      kp_step     <= 32'h0;
      ti_step     <= 32'h0;
      ramp_step   <= 32'h0;
      start_phase <= 1'b0;
      loop_output <= 32'h0;
      loop_active <= 1'b0;
    end else if (ce) begin
      loop_active <= run;
      if (!run) begin
        // Inactive: hold all terms at zero, arm the start ramp
        state       <= ST_IDLE;
        stage       <= 4'h0;
        p_term      <= 32'sh0;
        integ       <= 32'sh0;
        d_term      <= 32'sh0;
        err_prev    <= err;
        scaled      <= 32'sh0;
        lag_y       <= 32'sh0;
        loop_output <= 32'h0;
        start_phase <= (cfg[`EPL_I_SRAMP] != 32'h0);
      end else begin
        case (state)
          ST_IDLE: begin
            stage <= 4'h0;
            if (sample)
              state <= ST_LOAD;
          end
          ST_LOAD: state <= ST_WAIT;
          ST_WAIT: begin
            if (div_done) begin
              state <= ST_GAP;
              stage <= stage + 4'h1;
              case (stage)
                4'h0: kp_step <= quo[31:0];
                4'h1: ti_step <= quo[31:0];
                4'h2: ramp_step <= quo[31:0];
                4'h3: p_term <= div_res;
                4'h4: begin
                  if (ti_ms == 32'h0)
                    integ <= 32'sh0;
                  else if (integ_next > i_hi)
                    integ <= i_hi;
                  else if (integ_next < i_lo)
                    integ <= i_lo;
                  else
                    integ <= integ_next;
                end
                4'h5: begin
                  d_term   <= div_res;
                  err_prev <= err;
                end
                4'h6: scaled <= div_res;
                4'h7: lag_y <= lag_y + div_res;
                default: begin
                  // Fixed mode ignores main speed entirely
                  loop_output <= ctrl[`EPL_C_FIXED] ?
                                 ramp_int : div_res;
                  state <= ST_IDLE;
                end
              endcase
            end
          end
          ST_GAP: begin
            state <= ST_LOAD;
            if (ramp_tick && ramp_val == (lag_y <<< `EPL_RAMP_FRAC))
              start_phase <= 1'b0;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule
